// ==== hdl/decoder_consts.vh ====
`ifndef DECODER_CONSTS_VH
`define DECODER_CONSTS_VH

// quadrant codes, host_bus_address[33:32]
`define QUAD_CACHEABLE 2'h0
`define QUAD_IO 2'h1
`define QUAD_SPARSE_MEM 2'h2
`define QUAD_DENSE_MEM 2'h3

// space codes driven on space_q
`define SPACE_NONE 4'h0
`define SPACE_CACHEABLE 4'h1
`define SPACE_NONCACHEABLE 4'h2
`define SPACE_MEM_CSR 4'h3
`define SPACE_BRIDGE_CSR 4'h4
`define SPACE_INT_ACK 4'h5
`define SPACE_SPECIAL 4'h6
`define SPACE_SPARSE_IO 4'h7
`define SPACE_CONFIG_RD 4'h8
`define SPACE_CONFIG_WR 4'h9
`define SPACE_SPARSE_MEM 4'hA
`define SPACE_DENSE_MEM 4'hB

// csr register stride and offsets, address bits [27:0]
`define CSR_STRIDE 28'h0000020
`define MC_GEN_CTRL 28'h0000000
`define MC_ERR_DIAG 28'h0000040
`define MC_GLOBAL_TIMING 28'h0000200
`define MC_BANK_BASE 28'h0000800
`define MC_BANK_CONFIG 28'h0000A00
`define MC_BANK_TIMING_A 28'h0000C00
`define MC_BANK_TIMING_B 28'h0000E00
`define BR_CTRL_STATUS 28'h0000000
`define BR_PCI_FAULT 28'h0000020
`define BR_HOST_FAULT 28'h0000040
`define BR_PLACEHOLDER 28'h0000060
`define BR_DMA_WINDOW 28'h00000C0
`define BR_ADDR_EXT 28'h0000180
`define BR_LATENCY 28'h00001E0
`define BR_TAG 28'h0000200
`define BR_TDATA 28'h0000300
`define BR_FLUSH_ALL 28'h0000400

// sparse i/o: lowest 256KB of pci i/o space, host address bits [28:23] zero
`define SPARSE_IO_LOW_LSB 23

// csr select index codes, memory controller
`define MSEL_NONE 6'h00
`define MSEL_GEN_CTRL 6'h01
`define MSEL_ERR_DIAG 6'h02
`define MSEL_GLOBAL_TIMING 6'h03
`define MSEL_BANK_BASE 6'h04
`define MSEL_BANK_CONFIG 6'h05
`define MSEL_BANK_TIMING_A 6'h06
`define MSEL_BANK_TIMING_B 6'h07

// csr select index codes, bridge
`define BSEL_NONE 6'h00
`define BSEL_CTRL_STATUS 6'h01
`define BSEL_PCI_FAULT 6'h02
`define BSEL_HOST_FAULT 6'h03
`define BSEL_PLACEHOLDER 6'h04
`define BSEL_DMA_WINDOW 6'h05
`define BSEL_ADDR_EXT 6'h06
`define BSEL_LATENCY 6'h07
`define BSEL_TAG 6'h08
`define BSEL_TDATA 6'h09
`define BSEL_FLUSH_ALL 6'h0A

`endif

// ==== hdl/strided_match.v ====
`default_nettype none
// matches an offset against a strided group of registers
module strided_match #(
  parameter [27:0] BASE = 28'h0000000,
  parameter [27:0] STRIDE = 28'h0000020,
  parameter COUNT = 1
) (
  // offset in
  input wire [27:0] offset,
  // result
  output reg hit,
  output reg [3:0] index
);
  integer i;
  always @* begin
    hit = 1'b0;
    index = 4'h0;
    for (i = 0; i < COUNT; i = i + 1) begin
      if (offset == BASE + STRIDE * i[27:0]) begin
        hit = 1'b1;
        index = i[3:0];
      end
    end
  end
endmodule // strided_match
`default_nettype wire

// ==== hdl/csr_select.v ====
`default_nettype none
`include "decoder_consts.vh"
// picks one csr from the low 28 address bits, for either csr space
module csr_select (
  // offset in
  input wire [27:0] offset,
  // memory controller selection
  output reg [5:0] mc_sel,
  output reg [3:0] mc_idx,
  // bridge selection
  output reg [5:0] br_sel,
  output reg [3:0] br_idx
);
  wire hit_base, hit_cfg, hit_ta, hit_tb, hit_ph, hit_dma, hit_ext, hit_tag, hit_td;
  wire [3:0] i_base, i_cfg, i_ta, i_tb, i_ph, i_dma, i_ext, i_tag, i_td;

  strided_match #(.BASE(`MC_BANK_BASE), .STRIDE(`CSR_STRIDE), .COUNT(9)) m_base (
    .offset(offset), .hit(hit_base), .index(i_base));
  strided_match #(.BASE(`MC_BANK_CONFIG), .STRIDE(`CSR_STRIDE), .COUNT(9)) m_cfg (
    .offset(offset), .hit(hit_cfg), .index(i_cfg));
  // bank 5 lands on 0xCA0 by stride, clear of bank 5 configuration at 0xAA0
  strided_match #(.BASE(`MC_BANK_TIMING_A), .STRIDE(`CSR_STRIDE), .COUNT(9)) m_ta (
    .offset(offset), .hit(hit_ta), .index(i_ta));
  strided_match #(.BASE(`MC_BANK_TIMING_B), .STRIDE(`CSR_STRIDE), .COUNT(9)) m_tb (
    .offset(offset), .hit(hit_tb), .index(i_tb));
  strided_match #(.BASE(`BR_PLACEHOLDER), .STRIDE(`CSR_STRIDE), .COUNT(3)) m_ph (
    .offset(offset), .hit(hit_ph), .index(i_ph));
  strided_match #(.BASE(`BR_DMA_WINDOW), .STRIDE(`CSR_STRIDE), .COUNT(6)) m_dma (
    .offset(offset), .hit(hit_dma), .index(i_dma));
  strided_match #(.BASE(`BR_ADDR_EXT), .STRIDE(`CSR_STRIDE), .COUNT(3)) m_ext (
    .offset(offset), .hit(hit_ext), .index(i_ext));
  strided_match #(.BASE(`BR_TAG), .STRIDE(`CSR_STRIDE), .COUNT(8)) m_tag (
    .offset(offset), .hit(hit_tag), .index(i_tag));
  strided_match #(.BASE(`BR_TDATA), .STRIDE(`CSR_STRIDE), .COUNT(8)) m_td (
    .offset(offset), .hit(hit_td), .index(i_td));

  always @* begin
    mc_sel = `MSEL_NONE;
    mc_idx = 4'h0;
    if (offset == `MC_GEN_CTRL) begin
      mc_sel = `MSEL_GEN_CTRL;
    end else if (offset == `MC_ERR_DIAG) begin
      mc_sel = `MSEL_ERR_DIAG;
    end else if (offset == `MC_GLOBAL_TIMING) begin
      mc_sel = `MSEL_GLOBAL_TIMING;
    end else if (hit_base) begin
      mc_sel = `MSEL_BANK_BASE;
      mc_idx = i_base;
    end else if (hit_cfg) begin
      mc_sel = `MSEL_BANK_CONFIG;
      mc_idx = i_cfg;
    end else if (hit_ta) begin
      mc_sel = `MSEL_BANK_TIMING_A;
      mc_idx = i_ta;
    end else if (hit_tb) begin
      mc_sel = `MSEL_BANK_TIMING_B;
      mc_idx = i_tb;
    end
  end

  always @* begin
    br_sel = `BSEL_NONE;
    br_idx = 4'h0;
    if (offset == `BR_CTRL_STATUS) begin
      br_sel = `BSEL_CTRL_STATUS;
    end else if (offset == `BR_PCI_FAULT) begin
      br_sel = `BSEL_PCI_FAULT;
    end else if (offset == `BR_HOST_FAULT) begin
      br_sel = `BSEL_HOST_FAULT;
    end else if (hit_ph) begin
      br_sel = `BSEL_PLACEHOLDER;
      br_idx = i_ph;
    end else if (hit_dma) begin
      br_sel = `BSEL_DMA_WINDOW;
      br_idx = i_dma;
    end else if (hit_ext) begin
      br_sel = `BSEL_ADDR_EXT;
      br_idx = i_ext;
    end else if (offset == `BR_LATENCY) begin
      br_sel = `BSEL_LATENCY;
    end else if (hit_tag) begin
      br_sel = `BSEL_TAG;
      br_idx = i_tag;
    end else if (hit_td) begin
      br_sel = `BSEL_TDATA;
      br_idx = i_td;
    end else if (offset == `BR_FLUSH_ALL) begin
      br_sel = `BSEL_FLUSH_ALL;
    end
  end
endmodule // csr_select
`default_nettype wire

// ==== hdl/host_address_space_decoder.v ====
`default_nettype none
`include "decoder_consts.vh"
module host_address_space_decoder (
  // clock and reset
  input wire clk_sys,
  input wire rst,
  // host processor bus request
  input wire req_valid,
  input wire req_write,
  input wire req_ifetch,
  input wire req_dma,
  input wire [33:0] host_bus_address,
  // steering result, one cycle after the request
  output reg claim_valid_q,
  output reg [3:0] space_q,
  output reg mc_claim_q,
  output reg bridge_claim_q,
  output reg bypass_l2_q,
  output reg prefetch_ok_q,
  output reg sparse_q,
  output reg sparse_io_low_q,
  output reg fetch_error_q,
  // csr selection
  output reg [5:0] mc_sel_q,
  output reg [5:0] br_sel_q,
  output reg [3:0] csr_idx_q
);
  wire [1:0] quad = host_bus_address[33:32];
  wire [3:0] sub = host_bus_address[31:28];
  wire [5:0] mc_sel, br_sel;
  wire [3:0] mc_idx, br_idx;

  reg [3:0] space_d;
  reg mc_d, br_d, l2_bypass_d, prefetch_d, sparse_d, memory_d;

  csr_select u_sel (
    .offset(host_bus_address[27:0]),
    .mc_sel(mc_sel),
    .mc_idx(mc_idx),
    .br_sel(br_sel),
    .br_idx(br_idx)
  );

  always @* begin
    space_d = `SPACE_NONE;
    mc_d = 1'b0;
    br_d = 1'b0;
    l2_bypass_d = 1'b0;
    prefetch_d = 1'b0;
    sparse_d = 1'b0;
    memory_d = 1'b0;
    case (quad)
      `QUAD_CACHEABLE: begin
        space_d = `SPACE_CACHEABLE;
        mc_d = 1'b1;
        memory_d = 1'b1;
      end
      `QUAD_IO: begin
        if (!sub[3]) begin
          space_d = `SPACE_NONCACHEABLE;
          mc_d = 1'b1;
          l2_bypass_d = 1'b1;
          memory_d = 1'b1;
        end else if (sub[3:1] == 3'b100) begin
          space_d = `SPACE_MEM_CSR;
          mc_d = 1'b1;
        end else if (sub == 4'hA) begin
          space_d = `SPACE_BRIDGE_CSR;
          br_d = 1'b1;
        end else if (sub == 4'hB) begin
          space_d = req_write ? `SPACE_SPECIAL : `SPACE_INT_ACK;
          br_d = 1'b1;
        end else if (sub[3:1] == 3'b110) begin
          space_d = `SPACE_SPARSE_IO;
          br_d = 1'b1;
          sparse_d = 1'b1;
        end else begin
          space_d = req_write ? `SPACE_CONFIG_WR : `SPACE_CONFIG_RD;
          br_d = 1'b1;
        end
      end
      `QUAD_SPARSE_MEM: begin
        // only 2 0000 0000 to 2 7FFF FFFF is sparse memory
        if (!sub[3]) begin
          space_d = `SPACE_SPARSE_MEM;
          br_d = 1'b1;
          sparse_d = 1'b1;
        end
      end
      `QUAD_DENSE_MEM: begin
        space_d = `SPACE_DENSE_MEM;
        br_d = 1'b1;
        prefetch_d = 1'b1;
      end
      default: begin
        space_d = `SPACE_NONE;
      end
    endcase
  end

  always @(posedge clk_sys) begin
    if (rst) begin
      claim_valid_q <= 1'b0;
      space_q <= `SPACE_NONE;
      mc_claim_q <= 1'b0;
      bridge_claim_q <= 1'b0;
      bypass_l2_q <= 1'b0;
      prefetch_ok_q <= 1'b0;
      sparse_q <= 1'b0;
      sparse_io_low_q <= 1'b0;
      fetch_error_q <= 1'b0;
      mc_sel_q <= `MSEL_NONE;
      br_sel_q <= `BSEL_NONE;
      csr_idx_q <= 4'h0;
    end else begin
      claim_valid_q <= req_valid;
      space_q <= req_valid ? space_d : `SPACE_NONE;
      mc_claim_q <= req_valid & mc_d;
      bridge_claim_q <= req_valid & br_d;
      bypass_l2_q <= req_valid & l2_bypass_d;
      prefetch_ok_q <= req_valid & prefetch_d;
      sparse_q <= req_valid & sparse_d;
      sparse_io_low_q <= req_valid & (space_d == `SPACE_SPARSE_IO) &
        (host_bus_address[28:`SPARSE_IO_LOW_LSB] == 6'h00);
      // fetches and dma belong in cacheable and noncacheable memory only; flagged, not blocked
      fetch_error_q <= req_valid & (req_ifetch | req_dma) & ~memory_d;
      mc_sel_q <= (req_valid && space_d == `SPACE_MEM_CSR) ? mc_sel : `MSEL_NONE;
      br_sel_q <= (req_valid && space_d == `SPACE_BRIDGE_CSR) ? br_sel : `BSEL_NONE;
      csr_idx_q <= !req_valid ? 4'h0 : (space_d == `SPACE_MEM_CSR) ? mc_idx :
        (space_d == `SPACE_BRIDGE_CSR) ? br_idx : 4'h0;
    end
  end
endmodule // host_address_space_decoder
`default_nettype wire

// ==== testbench/decoder_properties.sv ====
`default_nettype none
`include "decoder_consts.vh"
module decoder_properties (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // request
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic req_ifetch,
  input wire logic req_dma,
  input wire logic [33:0] host_bus_address,
  // result
  input wire logic [3:0] space_q,
  input wire logic mc_claim_q,
  input wire logic bridge_claim_q,
  input wire logic bypass_l2_q,
  input wire logic prefetch_ok_q,
  input wire logic sparse_q,
  input wire logic fetch_error_q
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire [5:0] t = host_bus_address[33:28];
  wire rv = req_valid;
  property p_cache;
    rv && t[5:4] == 2'h0 |=> space_q == `SPACE_CACHEABLE && mc_claim_q && !bridge_claim_q;
  endproperty
  a_cache: assert property (p_cache) else $error("bad cacheable");
  property p_mem_fetch;
    rv && (t[5:4] == 2'h0 || t[5:3] == 3'h2) |=> !fetch_error_q;
  endproperty
  a_mem_fetch: assert property (p_mem_fetch) else $error("bad fetch flag");
  property p_nc;
    rv && t[5:3] == 3'h2 |=> bypass_l2_q && mc_claim_q && !bridge_claim_q;
  endproperty
  a_nc: assert property (p_nc) else $error("bad noncacheable");
  property p_mcsr;
    rv && t[5:1] == 5'h0C |=> space_q == `SPACE_MEM_CSR && mc_claim_q && !bridge_claim_q;
  endproperty
  a_mcsr: assert property (p_mcsr) else $error("bad mc csr");
  property p_brcsr;
    rv && t == 6'h1A |=> space_q == `SPACE_BRIDGE_CSR && bridge_claim_q && !mc_claim_q;
  endproperty
  a_brcsr: assert property (p_brcsr) else $error("bad bridge csr");
  property p_ack;
    rv && t == 6'h1B |=> space_q == ($past(req_write) ? `SPACE_SPECIAL : `SPACE_INT_ACK);
  endproperty
  a_ack: assert property (p_ack) else $error("bad int ack");
  property p_cfg;
    rv && t[5:1] == 5'h0F |=> space_q == ($past(req_write) ? `SPACE_CONFIG_WR : `SPACE_CONFIG_RD);
  endproperty
  a_cfg: assert property (p_cfg) else $error("bad config");
  property p_sparse;
    rv && t[5:3] == 3'h4 |=> space_q == `SPACE_SPARSE_MEM && sparse_q && !prefetch_ok_q;
  endproperty
  a_sparse: assert property (p_sparse) else $error("bad sparse");
  property p_dense;
    rv && t[5:4] == 2'h3 |=> space_q == `SPACE_DENSE_MEM && prefetch_ok_q && !sparse_q;
  endproperty
  a_dense: assert property (p_dense) else $error("bad dense");
  property p_fetch_err;
    rv && (req_ifetch || req_dma) && !(t[5:4] == 2'h0 || t[5:3] == 3'h2) |=> fetch_error_q;
  endproperty
  a_fetch_err: assert property (p_fetch_err) else $error("missed fetch flag");
  property p_one_owner;
    rv |=> !(mc_claim_q && bridge_claim_q);
  endproperty
  a_one_owner: assert property (p_one_owner) else $error("double claim");
endmodule // decoder_properties
bind host_address_space_decoder decoder_properties chk_u (.clk_sys, .rst, .req_valid, .req_write,
  .req_ifetch, .req_dma, .host_bus_address, .space_q, .mc_claim_q, .bridge_claim_q, .bypass_l2_q,
  .prefetch_ok_q, .sparse_q, .fetch_error_q);
`default_nettype wire

// ==== testbench/host_core_model.sv ====
`default_nettype none
module host_core_model (
  // clock
  input wire logic clk_sys,
  // request out
  output logic req_valid,
  output logic req_write,
  output logic req_ifetch,
  output logic req_dma,
  output logic [33:0] host_bus_address
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {req_valid, req_write, req_ifetch, req_dma, host_bus_address} = 38'h0;
  // back-to-back calls keep req_valid high, one request per edge
  task issue(input logic [33:0] a, input logic w, input logic f, input logic d);
    @(negedge clk_sys);
    req_valid = 1'h1;
    req_write = w;
    req_ifetch = f;
    req_dma = d;
    host_bus_address = a;
    @(posedge clk_sys);
  endtask
  // released address lines show the inverse; write, fetch and dma lines keep their last values
  task idle();
    @(negedge clk_sys);
    req_valid = 1'h0;
    host_bus_address = ~host_bus_address;
  endtask
endmodule // host_core_model
`default_nettype wire

// ==== testbench/test_host_address_space_decoder.sv ====
`default_nettype none
`include "decoder_consts.vh"
module test_host_address_space_decoder;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'h0;
  logic rst = 1'h1;
  wire req_valid, req_write, req_ifetch, req_dma, claim_valid_q, mc_claim_q, bridge_claim_q;
  wire bypass_l2_q, prefetch_ok_q, sparse_q, sparse_io_low_q, fetch_error_q;
  wire [33:0] host_bus_address;
  wire [3:0] space_q, csr_idx_q;
  wire [5:0] mc_sel_q, br_sel_q;
  int failures = 0;
  int checked = 0;
  always #5 clk_sys = ~clk_sys;
  host_core_model cpu_u (.clk_sys(clk_sys), .req_valid(req_valid), .req_write(req_write),
    .req_ifetch(req_ifetch), .req_dma(req_dma), .host_bus_address(host_bus_address));
  host_address_space_decoder dut_u (.clk_sys(clk_sys), .rst(rst), .req_valid(req_valid),
    .req_write(req_write), .req_ifetch(req_ifetch), .req_dma(req_dma), .host_bus_address(host_bus_address),
    .claim_valid_q(claim_valid_q), .space_q(space_q), .mc_claim_q(mc_claim_q),
    .bridge_claim_q(bridge_claim_q), .bypass_l2_q(bypass_l2_q), .prefetch_ok_q(prefetch_ok_q),
    .sparse_q(sparse_q), .sparse_io_low_q(sparse_io_low_q), .fetch_error_q(fetch_error_q),
    .mc_sel_q(mc_sel_q), .br_sel_q(br_sel_q), .csr_idx_q(csr_idx_q));
  task results();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // answer lands one edge after the request
  task go(input logic [33:0] a, input logic w, input logic f, input logic d);
    cpu_u.issue(a, w, f, d);
    #1;
    chk(8'(claim_valid_q), 8'h01);
  endtask
  task sp(input logic [33:0] a, input logic w, input logic [3:0] s, input logic [4:0] fl);
    go(a, w, 1'h0, 1'h0);
    chk(8'(space_q), 8'(s));
    chk(8'({mc_claim_q, bridge_claim_q, bypass_l2_q, prefetch_ok_q, sparse_q}), 8'(fl));
  endtask
  task cs(input logic [33:0] a, input logic [5:0] m, input logic [5:0] b, input logic [3:0] i);
    go(a, 1'h0, 1'h0, 1'h0);
    chk(8'(mc_sel_q), 8'(m));
    chk(8'(br_sel_q), 8'(b));
    chk(8'(csr_idx_q), 8'(i));
  endtask
  task t_spaces();
    sp(34'h0_1234_5678, 1'h0, `SPACE_CACHEABLE, 5'h10);
    sp(34'h1_7FFF_FFF8, 1'h1, `SPACE_NONCACHEABLE, 5'h14);
    sp(34'h1_9FFF_FFE0, 1'h0, `SPACE_MEM_CSR, 5'h10);
    sp(34'h1_AFFF_FFE0, 1'h1, `SPACE_BRIDGE_CSR, 5'h08);
    sp(34'h1_B000_0000, 1'h0, `SPACE_INT_ACK, 5'h08);
    sp(34'h1_BFFF_FFF8, 1'h1, `SPACE_SPECIAL, 5'h08);
    sp(34'h1_DFFF_FFF8, 1'h0, `SPACE_SPARSE_IO, 5'h09);
    sp(34'h1_E000_0000, 1'h0, `SPACE_CONFIG_RD, 5'h08);
    sp(34'h1_FFFF_FFF8, 1'h1, `SPACE_CONFIG_WR, 5'h08);
    sp(34'h2_7FFF_FFF8, 1'h0, `SPACE_SPARSE_MEM, 5'h09);
    sp(34'h2_8000_0000, 1'h0, `SPACE_NONE, 5'h00);
    sp(34'h3_FFFF_FFF8, 1'h1, `SPACE_DENSE_MEM, 5'h0A);
    cpu_u.idle();
    @(posedge clk_sys);
    #1;
    chk(8'({claim_valid_q, space_q}), 8'h00);
    $display("t_spaces done");
  endtask
  task t_csrs();
    cs(34'h1_8000_0000, `MSEL_GEN_CTRL, 6'h00, 4'h0);
    cs(34'h1_8000_0040, `MSEL_ERR_DIAG, 6'h00, 4'h0);
    cs(34'h1_8000_0200, `MSEL_GLOBAL_TIMING, 6'h00, 4'h0);
    cs(34'h1_8000_0900, `MSEL_BANK_BASE, 6'h00, 4'h8);
    cs(34'h1_8000_0AA0, `MSEL_BANK_CONFIG, 6'h00, 4'h5);
    cs(34'h1_8000_0E00, `MSEL_BANK_TIMING_B, 6'h00, 4'h0);
    cs(34'h1_8000_0D00, `MSEL_BANK_TIMING_A, 6'h00, 4'h8);
    cs(34'h1_8000_0CA0, `MSEL_BANK_TIMING_A, 6'h00, 4'h5);
    cs(34'h1_A000_0000, 6'h00, `BSEL_CTRL_STATUS, 4'h0);
    cs(34'h1_A000_0020, 6'h00, `BSEL_PCI_FAULT, 4'h0);
    cs(34'h1_A000_0040, 6'h00, `BSEL_HOST_FAULT, 4'h0);
    cs(34'h1_A000_01A0, 6'h00, `BSEL_ADDR_EXT, 4'h1);
    cs(34'h1_A000_0160, 6'h00, `BSEL_DMA_WINDOW, 4'h5);
    cs(34'h1_A000_01E0, 6'h00, `BSEL_LATENCY, 4'h0);
    cs(34'h1_A000_02E0, 6'h00, `BSEL_TAG, 4'h7);
    cs(34'h1_A000_0300, 6'h00, `BSEL_TDATA, 4'h0);
    cs(34'h1_A000_00A0, 6'h00, `BSEL_PLACEHOLDER, 4'h2);
    cs(34'h1_A000_0400, 6'h00, `BSEL_FLUSH_ALL, 4'h0);
    cpu_u.idle();
    $display("t_csrs done");
  endtask
  task t_fetch_io();
    go(34'h0_0000_0000, 1'h0, 1'h1, 1'h0);
    chk(8'(fetch_error_q), 8'h00);
    go(34'h1_7000_0000, 1'h0, 1'h0, 1'h1);
    chk(8'(fetch_error_q), 8'h00);
    go(34'h1_A000_0000, 1'h0, 1'h1, 1'h0);
    chk(8'(fetch_error_q), 8'h01);
    go(34'h3_0000_0000, 1'h0, 1'h0, 1'h1);
    chk(8'(fetch_error_q), 8'h01);
    go(34'h2_8000_0000, 1'h0, 1'h1, 1'h0);
    chk(8'(fetch_error_q), 8'h01);
    go(34'h1_C07F_FFF8, 1'h0, 1'h0, 1'h0);
    chk(8'(sparse_io_low_q), 8'h01);
    go(34'h1_C080_0000, 1'h1, 1'h0, 1'h0);
    chk(8'(sparse_io_low_q), 8'h00);
    go(34'h1_E000_0000, 1'h0, 1'h0, 1'h0);
    chk(8'(sparse_io_low_q), 8'h00);
    cpu_u.idle();
    $display("t_fetch_io done");
  endtask
  initial begin
    repeat (5) @(posedge clk_sys);
    @(negedge clk_sys);
    chk(8'({claim_valid_q, space_q}), 8'h00);
    rst = 1'h0;
    t_spaces();
    t_csrs();
    t_fetch_io();
    results();
  end
  initial begin
    #100000;
    failures++;
    results();
  end
endmodule // test_host_address_space_decoder
`default_nettype wire
